/* logic/banked_memory_address_map.sv */
`timescale 1ns/1ps
`include "banked_map_regs.svh"
`default_nettype none
module banked_memory_address_map #(
    parameter int PC_WIDTH = 13,
    parameter int RAM_DEPTH = 128
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // fetch side
    input wire logic fetch_advance_in,
    input wire logic fetch_load_in,
    input wire logic [PC_WIDTH-1:0] fetch_target_in,
    input wire logic irq_take_in,
    output logic [PC_WIDTH-1:0] pc_out,
    output logic [10:0] prog_addr_out,
    output banked_map_pkg::fetch_state_t fetch_state_out,
    // data side
    input wire logic data_req_in,
    input wire logic data_we_in,
    input wire logic data_indirect_in,
    input wire logic [6:0] data_field_in,
    input wire logic [7:0] indirect_pointer_in,
    input wire logic bank_select_bit_in,
    input wire logic reserved_bank_high_bit_in,
    input wire logic reserved_indirect_bank_bit_in,
    input wire logic [7:0] data_wdata_in,
    output logic [7:0] data_rdata_out,
    output logic data_valid_out,
    output logic sfs_sel_out,
    output logic [7:0] sfs_addr_out,
    output logic sfs_we_out,
    output logic [7:0] sfs_wdata_out,
    output banked_map_pkg::region_t region_out
);
    import banked_map_pkg::*;

    logic [PC_WIDTH-1:0] pc_q;
    logic [PC_WIDTH-1:0] pc_d;
    fetch_state_t fstate_q;
    fetch_state_t fstate_d;
    logic [7:0] ram_q [RAM_DEPTH];
    logic [7:0] full_addr;
    logic [6:0] ram_idx;
    region_t region;

    function automatic region_t decode_region(input logic [7:0] a);
        if (a[6:0] <= `SFS_TOP) begin
            decode_region = REGION_SFS;
        end else if (a >= `BANK0_RAM_LO && a <= `BANK0_RAM_HI) begin
            decode_region = REGION_RAM;
        end else if (a >= `BANK1_RAM_LO && a <= `BANK1_RAM_HI) begin
            decode_region = REGION_RAM;
        end else if (a >= `MIRROR_LO) begin
            decode_region = REGION_RAM;
        end else begin
            decode_region = REGION_NONE;
        end
    endfunction

    function automatic logic [6:0] ram_index(input logic [7:0] a);
        logic [7:0] m;
        m = (a >= `MIRROR_LO) ? a - `MIRROR_OFFSET : a;
        ram_index = (m[7] ? m[6:0] - 7'h20 + 7'h60 : m[6:0] - 7'h20);
    endfunction

    // program counter
    always_comb begin
        pc_d = pc_q;
        if (irq_take_in) begin
            pc_d = `PC_IRQ_VEC;
        end else if (fetch_load_in) begin
            pc_d = fetch_target_in;
        end else if (fetch_advance_in) begin
            pc_d = pc_q + 13'h0001;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            pc_q <= `PC_RESET_VEC;
            pc_out <= `PC_RESET_VEC;
            prog_addr_out <= 11'h000;
            fstate_q <= FETCH_RESET;
            fetch_state_out <= FETCH_RESET;
        end else begin
            pc_q <= pc_d;
            pc_out <= pc_d;
            prog_addr_out <= pc_d[10:0];
            fstate_q <= fstate_d;
            fetch_state_out <= fstate_d;
        end
    end

    // fetch state, gray along reset -> run -> irq
    always_comb begin
        fstate_d = FETCH_RUN;
        case (fstate_q)
            FETCH_RESET: fstate_d = irq_take_in ? FETCH_IRQ : FETCH_RUN;
            FETCH_RUN: fstate_d = irq_take_in ? FETCH_IRQ : FETCH_RUN;
            FETCH_IRQ: fstate_d = irq_take_in ? FETCH_IRQ : FETCH_RUN;
            default: fstate_d = FETCH_RUN;
        endcase
    end

    // data address formation
    always_comb begin
        if (data_indirect_in || data_field_in == `INDIRECT_ADDR) begin
            full_addr = indirect_pointer_in;
        end else begin
            full_addr = {bank_select_bit_in, data_field_in};
        end
        region = decode_region(full_addr);
        ram_idx = ram_index(full_addr);
    end

    always_ff @(posedge mclk_in) begin
        if (data_req_in && data_we_in && region == REGION_RAM) begin
            ram_q[ram_idx] <= data_wdata_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            data_rdata_out <= 8'h00;
            data_valid_out <= 1'b0;
            sfs_sel_out <= 1'b0;
            sfs_addr_out <= 8'h00;
            sfs_we_out <= 1'b0;
            sfs_wdata_out <= 8'h00;
            region_out <= REGION_NONE;
        end else begin
            data_valid_out <= data_req_in;
            region_out <= data_req_in ? region : REGION_NONE;
            sfs_sel_out <= data_req_in && region == REGION_SFS;
            sfs_addr_out <= full_addr;
            sfs_we_out <= data_req_in && data_we_in && region == REGION_SFS;
            sfs_wdata_out <= data_wdata_in;
            if (data_req_in && !data_we_in && region == REGION_RAM) begin
                data_rdata_out <= ram_q[ram_idx];
            end else begin
                data_rdata_out <= 8'h00;
            end
        end
    end

    logic unused_reserved;
    assign unused_reserved = reserved_bank_high_bit_in
        ^ reserved_indirect_bank_bit_in;

    a_reset_entry: assert property (@(posedge mclk_in)
        sys_rst_in |=> pc_out == 13'h0000)
        else $error("pc not at reset entry");
    a_irq_entry: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in) irq_take_in |=> pc_out == 13'h0004)
        else $error("pc not at interrupt entry");
    a_prog_wrap: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        fetch_load_in && !irq_take_in
        |=> prog_addr_out == $past(fetch_target_in[10:0]))
        else $error("program address not wrapped");
    a_pc_step: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        fetch_advance_in && !fetch_load_in && !irq_take_in
        |=> pc_out == $past(pc_q) + 13'h0001)
        else $error("pc did not advance");
    a_unimpl_zero: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        region_out != REGION_RAM |-> data_rdata_out == 8'h00)
        else $error("unimplemented read not zero");
    a_sfs_low: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        data_req_in && full_addr[6:0] < 7'h20 |=> sfs_sel_out)
        else $error("low locations not special");
    a_bank_pick: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        data_req_in && !data_indirect_in && data_field_in != 7'h00
        |=> sfs_addr_out[7] == $past(bank_select_bit_in))
        else $error("bank select ignored");
    a_mirror_same: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        full_addr >= 8'hF0 |-> ram_idx == full_addr[6:0] - 7'h20)
        else $error("mirror mismatch");
    a_ram_range: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        data_req_in && full_addr >= 8'hA0 && full_addr <= 8'hBF
        |=> region_out == REGION_RAM)
        else $error("bank 1 ram not decoded");
    a_bank0_ram: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        data_req_in && full_addr >= 8'h20 && full_addr <= 8'h7F
        |=> region_out == REGION_RAM)
        else $error("bank 0 ram not decoded");
    a_mirror_ram: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        data_req_in && full_addr >= 8'hF0
        |=> region_out == REGION_RAM)
        else $error("mirror window not decoded");
    a_gap_none: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        data_req_in && full_addr >= 8'hC0 && full_addr <= 8'hEF
        |=> region_out == REGION_NONE && data_rdata_out == 8'h00)
        else $error("gap location not empty");
    a_ptr_path: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        data_req_in && data_indirect_in
        |=> sfs_addr_out == $past(indirect_pointer_in))
        else $error("pointer address not used");
    a_state_irq: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        irq_take_in |=> fetch_state_out == FETCH_IRQ)
        else $error("fetch state missed interrupt");

    // reset released after being held for at least one edge
    sequence s_rst_release;
        sys_rst_in ##1 !sys_rst_in;
    endsequence
    a_release_entry: assert property (@(posedge mclk_in)
        s_rst_release
        |-> pc_out == 13'h0000 && fetch_state_out == FETCH_RESET)
        else $error("fetch not at entry after reset");

    // ram write followed by a read of the same cell
    sequence s_ram_write;
        data_req_in && data_we_in && region == REGION_RAM;
    endsequence
    sequence s_ram_readback;
        s_ram_write ##1 (data_req_in && !data_we_in
            && region == REGION_RAM && $stable(ram_idx));
    endsequence
    a_ram_readback: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        s_ram_readback |=> data_rdata_out == $past(data_wdata_in, 2))
        else $error("ram read back differs");
endmodule
`default_nettype wire

/* logic/banked_map_regs.svh */
`ifndef BANKED_MAP_REGS_SVH
`define BANKED_MAP_REGS_SVH
`define PC_RESET_VEC 13'h0000
`define PC_IRQ_VEC 13'h0004
`define PROG_IMPL_MASK 13'h07FF
`define SFS_TOP 7'h1F
`define BANK0_RAM_LO 8'h20
`define BANK0_RAM_HI 8'h7F
`define BANK1_RAM_LO 8'hA0
`define BANK1_RAM_HI 8'hBF
`define MIRROR_LO 8'hF0
`define MIRROR_HI 8'hFF
`define MIRROR_OFFSET 8'h80
`define INDIRECT_ADDR 7'h00
`endif

/* logic/banked_map_pkg.sv */
package banked_map_pkg;
    typedef enum logic [1:0] {
        REGION_NONE = 2'b00,
        REGION_SFS = 2'b01,
        REGION_RAM = 2'b11
    } region_t;
    typedef enum logic [1:0] {
        FETCH_RESET = 2'b00,
        FETCH_RUN = 2'b01,
        FETCH_IRQ = 2'b11
    } fetch_state_t;
endpackage

/* tb/core_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
    // status bits held by core software
    output logic reserved_bank_high_bit_out,
    output logic reserved_indirect_bank_bit_out
);
    assign reserved_bank_high_bit_out = 1'b0;
    assign reserved_indirect_bank_bit_out = 1'b0;
endmodule
`default_nettype wire

/* tb/tb_banked_memory_address_map.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_banked_memory_address_map;
    import banked_map_pkg::*;
    logic mclk_in = 0, sys_rst_in = 1, adv = 0, ld = 0, irq = 0;
    logic req = 0, we = 0, ind = 0, bank = 0, hi, ip, vld;
    logic [6:0] field = 0;
    logic [7:0] ptr = 0, wd = 0, rd;
    logic [12:0] tgt = 0, pc;
    logic [10:0] pa;
    fetch_state_t fs;
    region_t rg;
    logic [7:0] mem [0:255];
    logic [27:0] exp_q [$];
    logic [27:0] ew;
    logic [31:0] rnd;
    logic ssel, swe;
    logic [7:0] sadr, swd;
    int n_errors = 0, compares = 0, cyc = 0;
    int seed = 32'hbe8e_30ae;
    always #12.5 mclk_in = ~mclk_in;
    core_side_model core (.reserved_bank_high_bit_out(hi),
        .reserved_indirect_bank_bit_out(ip));
    banked_memory_address_map dut (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .fetch_advance_in(adv),
        .fetch_load_in(ld), .fetch_target_in(tgt), .irq_take_in(irq),
        .pc_out(pc), .prog_addr_out(pa), .fetch_state_out(fs),
        .data_req_in(req), .data_we_in(we), .data_indirect_in(ind),
        .data_field_in(field), .indirect_pointer_in(ptr),
        .bank_select_bit_in(bank), .reserved_bank_high_bit_in(hi),
        .reserved_indirect_bank_bit_in(ip), .data_wdata_in(wd),
        .data_rdata_out(rd), .data_valid_out(vld), .sfs_sel_out(ssel),
        .sfs_addr_out(sadr), .sfs_we_out(swe), .sfs_wdata_out(swd),
        .region_out(rg));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task fet(input logic a, l, q, input logic [12:0] t, e);
        {adv, ld, irq, tgt} = {a, l, q, t};
        @(negedge mclk_in);
        chk(pc, e);
        chk({2'b00, pa}, e & 13'h07ff);
        chk(fs, q ? FETCH_IRQ : FETCH_RUN);
    endtask
    task acc(input logic w, i, b, input logic [6:0] f, input logic [7:0] p);
        logic [7:0] a;
        logic [7:0] m;
        logic [7:0] d;
        logic [31:0] rv;
        region_t r;
        rv = $random(seed);
        d = rv[7:0];
        a = (i || f == 7'h00) ? p : {b, f};
        if (a[6:0] < 7'h20) r = REGION_SFS;
        else if (a < 8'h80 || (a >= 8'ha0 && a < 8'hc0)) r = REGION_RAM;
        else if (a >= 8'hf0) r = REGION_RAM;
        else r = REGION_NONE;
        m = (a >= 8'hf0) ? a - 8'h80 : a;
        if (w && r == REGION_RAM) mem[m] = d;
        exp_q.push_back({r == REGION_SFS, w && r == REGION_SFS, a, d, r,
            (!w && r == REGION_RAM) ? mem[m] : 8'h00});
        {req, we, ind, bank, field, ptr, wd} = {1'b1, w, i, b, f, p, d};
        @(negedge mclk_in);
    endtask
    always @(negedge mclk_in) begin
        if (vld === 1'b1) begin
            if (exp_q.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
            else begin
                ew = exp_q.pop_front();
                chk({rg, rd}, ew[9:0]);
                chk({ssel, swe, sadr, swd}, ew[27:10]);
            end
        end
    end
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            n_errors++;
            close_out;
        end
    end
    initial begin
        repeat (8) @(negedge mclk_in);
        chk(fs, FETCH_RESET);
        sys_rst_in = 0;
        @(negedge mclk_in);
        chk(pc, 13'h0000);
        fet(0, 1, 0, 13'h1ffe, 13'h1ffe);
        fet(1, 0, 0, 13'h0000, 13'h1fff);
        fet(1, 0, 0, 13'h0000, 13'h0000);
        fet(1, 1, 1, 13'h0123, 13'h0004);
        fet(0, 1, 0, 13'h0abc, 13'h0abc);
        fet(0, 0, 0, 13'h0000, 13'h0abc);
        sys_rst_in = 1;
        repeat (2) @(negedge mclk_in);
        chk(pc, 13'h0000);
        chk(pa, 11'h000);
        sys_rst_in = 0;
        fet(1, 0, 0, 13'h0000, 13'h0001);
        acc(1, 0, 0, 7'h70, 8'h00);
        acc(0, 0, 1, 7'h70, 8'h00);
        acc(1, 0, 0, 7'h20, 8'h00);
        acc(1, 0, 1, 7'h20, 8'h00);
        acc(0, 0, 0, 7'h20, 8'h00);
        acc(0, 1, 0, 7'h00, 8'ha0);
        acc(1, 0, 1, 7'h40, 8'h00);
        acc(0, 0, 1, 7'h40, 8'h00);
        acc(0, 0, 1, 7'h05, 8'h00);
        acc(1, 0, 1, 7'h05, 8'h00);
        acc(0, 0, 0, 7'h20, 8'h00);
        acc(0, 0, 1, 7'h00, 8'h70);
        repeat (16) begin
            rnd = $random(seed);
            acc(1, rnd[16], rnd[15], rnd[14:8], rnd[7:0]);
            acc(0, rnd[16], rnd[15], rnd[14:8], rnd[7:0]);
        end
        req = 0;
        repeat (3) @(negedge mclk_in);
        chk(exp_q.size(), 13'h0000);
        close_out;
    end
endmodule
`default_nettype wire
